// File: rtl/ldcr_pkg.sv
package ldcr_pkg;

    // register byte offsets on the serial host bus
    localparam logic [7:0] ADDR_EN_HIGH = 8'h00;
    localparam logic [7:0] ADDR_EN_LOW = 8'h01;
    localparam logic [7:0] ADDR_PER_HIGH = 8'h02;
    localparam logic [7:0] ADDR_PER_LOW = 8'h03;
    localparam logic [7:0] ADDR_OVP = 8'h04;
    localparam logic [7:0] ADDR_DITHER = 8'h05;
    localparam logic [7:0] ADDR_HOLD_HIGH = 8'h38;
    localparam logic [7:0] ADDR_HOLD_LOW = 8'h39;

    // field widths and positions
    localparam int NUM_CH = 8;
    localparam int PER_W = 13;
    localparam int PER_HIGH_W = 5;
    localparam int OVP_W = 5;
    localparam int HOLD_W = 12;
    localparam int HOLD_HIGH_W = 4;
    localparam int DERATE_BIT = 2;
    localparam int DITHER_MSB = 1;
    localparam int DITHER_LSB = 0;

    // reset values
    localparam logic [7:0] RST_EN_HIGH = 8'h03;
    localparam logic [7:0] RST_EN_LOW = 8'hff;
    localparam logic [4:0] RST_PER_HIGH = 5'h0f;
    localparam logic [7:0] RST_PER_LOW = 8'hff;
    localparam logic [4:0] RST_OVP = 5'h1c;
    localparam logic RST_DERATE = 1'b0;
    localparam logic [1:0] RST_DITHER = 2'h0;
    localparam logic [1:0] DITHER_OFF = 2'h0;

    // timing
    localparam int CLK_NS = 50;
    localparam int STEP_NS = 1500;
    localparam int ONTIME_MAX_NS = 9830000;
    localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ONTIME_MAX_STEPS = ONTIME_MAX_NS / STEP_NS;

    // serial bus slave address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_CHECK = 2'b01,
        ST_RUN = 2'b11,
        ST_HALT = 2'b10
    } ldcr_start_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ACK = 3'b011,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b110,
        BUS_RACK = 3'b111,
        BUS_RLOAD = 3'b101
    } ldcr_bus_t;

endpackage

// File: rtl/ldcr_top.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - eight enable bits, all set at reset; bit k drives channel k+1 only once register 0x00 (reset 0x03) is zero
// - enabled unpopulated channel halts startup, stays dark, fault low
// - hold bits latch and clear only where host writes a one
// - period is (N+1) steps of 1.5 us, N from high and low bytes
// - period value resets to 0x0fff, 4096 steps
// - on-time clamped at ONTIME_MAX_STEPS steps (9.830 ms) by comparing the period position, capping duty cycle
// - 5-bit overvoltage trip code, 8 V plus 1 V per step, reset 0x1c
// - bit 2 enables thermal derating, reset disabled
// - 2-bit dither field: off, 5, 10, 15 percent, reset off
// - no dithering while frequency comes from external sync input
module ldcr_top #(
    parameter int ONTIME_MAX_STEPS = ldcr_pkg::ONTIME_MAX_STEPS,
    parameter logic [6:0] DEV_ADDR = ldcr_pkg::DEV_ADDR
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [7:0] unpopulated_i,
    input wire logic freq_set_or_external_sync_pin_i,
    input wire logic startup_req_i,
    input wire logic [11:0] fault_event_i,
    input wire logic [7:0][12:0] ontime_i,
    output logic [7:0] led_on_o,
    output logic fault_n_o,
    output logic [4:0] overvoltage_trip_code_o,
    output logic thermal_derate_enable_o,
    output logic [1:0] dither_o
);

    localparam logic [12:0] ONTIME_MAX = 13'(ONTIME_MAX_STEPS);
    localparam logic [4:0] STEP_LAST = 5'(ldcr_pkg::STEP_CYCLES - 1);

    // pin synchronisers
    logic [1:0] scl_sync_reg, sda_sync_reg, ext_sync_reg;
    logic [7:0] unpop_meta_reg, unpop_reg;
    logic scl_prev_reg, sda_prev_reg;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            ext_sync_reg <= 2'h0;
            unpop_meta_reg <= 8'h00;
            unpop_reg <= 8'h00;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            ext_sync_reg <= {ext_sync_reg[0], freq_set_or_external_sync_pin_i};
            unpop_meta_reg <= unpopulated_i;
            unpop_reg <= unpop_meta_reg;
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // configuration registers
    logic [7:0] en_high_reg, en_low_reg, per_low_reg;
    logic [4:0] per_high_reg, ovp_reg;
    logic derate_reg;
    logic [1:0] dither_reg;
    logic [11:0] hold_reg;
    logic wr_pulse;
    logic [7:0] ptr_reg, shift_reg;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            en_high_reg <= ldcr_pkg::RST_EN_HIGH;
            en_low_reg <= ldcr_pkg::RST_EN_LOW;
            per_high_reg <= ldcr_pkg::RST_PER_HIGH;
            per_low_reg <= ldcr_pkg::RST_PER_LOW;
            ovp_reg <= ldcr_pkg::RST_OVP;
            derate_reg <= ldcr_pkg::RST_DERATE;
            dither_reg <= ldcr_pkg::RST_DITHER;
        end else if (wr_pulse) begin
            unique case (ptr_reg)
                ldcr_pkg::ADDR_EN_HIGH: en_high_reg <= shift_reg;
                ldcr_pkg::ADDR_EN_LOW: en_low_reg <= shift_reg;
                ldcr_pkg::ADDR_PER_HIGH:
                    per_high_reg <= shift_reg[ldcr_pkg::PER_HIGH_W-1:0];
                ldcr_pkg::ADDR_PER_LOW: per_low_reg <= shift_reg;
                ldcr_pkg::ADDR_OVP: ovp_reg <= shift_reg[ldcr_pkg::OVP_W-1:0];
                ldcr_pkg::ADDR_DITHER: begin
                    derate_reg <= shift_reg[ldcr_pkg::DERATE_BIT];
                    dither_reg <= shift_reg[ldcr_pkg::DITHER_MSB:
                                            ldcr_pkg::DITHER_LSB];
                end
                default: ;
            endcase
        end
    end

    // latched fault hold, set wins over clear
    logic [11:0] hold_clr;
    always_comb begin
        hold_clr = 12'h000;
        if (wr_pulse && ptr_reg == ldcr_pkg::ADDR_HOLD_HIGH)
            hold_clr[11:8] = shift_reg[ldcr_pkg::HOLD_HIGH_W-1:0];
        if (wr_pulse && ptr_reg == ldcr_pkg::ADDR_HOLD_LOW)
            hold_clr[7:0] = shift_reg;
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i)
            hold_reg <= 12'h000;
        else
            hold_reg <= (hold_reg & ~hold_clr) | fault_event_i;
    end

    // read mux, unused bits zero
    function automatic logic [7:0] read_byte(input logic [7:0] a);
        unique case (a)
            ldcr_pkg::ADDR_EN_HIGH: read_byte = en_high_reg;
            ldcr_pkg::ADDR_EN_LOW: read_byte = en_low_reg;
            ldcr_pkg::ADDR_PER_HIGH: read_byte = {3'h0, per_high_reg};
            ldcr_pkg::ADDR_PER_LOW: read_byte = per_low_reg;
            ldcr_pkg::ADDR_OVP: read_byte = {3'h0, ovp_reg};
            ldcr_pkg::ADDR_DITHER:
                read_byte = {5'h00, derate_reg, dither_reg};
            ldcr_pkg::ADDR_HOLD_HIGH: read_byte = {4'h0, hold_reg[11:8]};
            ldcr_pkg::ADDR_HOLD_LOW: read_byte = hold_reg[7:0];
            default: read_byte = 8'h00;
        endcase
    endfunction

    // serial bus slave
    ldcr_pkg::ldcr_bus_t bus_reg;
    logic [2:0] bit_reg;
    logic rw_reg, first_reg, ack_on_reg, sda_oe_reg;
    logic [7:0] rbyte;
    logic shift_valid_reg;
    always_comb rbyte = read_byte(ptr_reg);
    assign wr_pulse = (bus_reg == ldcr_pkg::BUS_ACK) && scl_fall
                      && !ack_on_reg && !rw_reg && !first_reg
                      && shift_valid_reg;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            bus_reg <= ldcr_pkg::BUS_IDLE;
            bit_reg <= 3'h0;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            ack_on_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ptr_reg <= 8'h00;
            shift_reg <= 8'h00;
            shift_valid_reg <= 1'b0;
        end else if (bus_start) begin
            bus_reg <= ldcr_pkg::BUS_ADDR;
            bit_reg <= 3'h0;
            first_reg <= 1'b1;
            rw_reg <= 1'b0;
            ack_on_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            shift_valid_reg <= 1'b0;
        end else if (bus_stop) begin
            bus_reg <= ldcr_pkg::BUS_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            unique case (bus_reg)
                ldcr_pkg::BUS_IDLE: ;
                ldcr_pkg::BUS_ADDR, ldcr_pkg::BUS_WRITE: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            if (bus_reg == ldcr_pkg::BUS_ADDR) begin
                                rw_reg <= sda_s;
                                shift_valid_reg <= 1'b0;
                                bus_reg <= (shift_reg[6:0] == DEV_ADDR)
                                    ? ldcr_pkg::BUS_ACK
                                    : ldcr_pkg::BUS_IDLE;
                            end else begin
                                shift_valid_reg <= 1'b1;
                                bus_reg <= ldcr_pkg::BUS_ACK;
                            end
                        end
                    end
                end
                ldcr_pkg::BUS_ACK: begin
                    if (scl_fall && !ack_on_reg) begin
                        ack_on_reg <= 1'b1;
                        sda_oe_reg <= 1'b1;
                        if (shift_valid_reg && first_reg) begin
                            ptr_reg <= shift_reg;
                            first_reg <= 1'b0;
                        end else if (wr_pulse) begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                    end else if (scl_fall) begin
                        ack_on_reg <= 1'b0;
                        bit_reg <= 3'h0;
                        if (rw_reg) begin
                            shift_reg <= rbyte;
                            sda_oe_reg <= ~rbyte[7];
                            ptr_reg <= ptr_reg + 8'h01;
                            bus_reg <= ldcr_pkg::BUS_READ;
                        end else begin
                            sda_oe_reg <= 1'b0;
                            bus_reg <= ldcr_pkg::BUS_WRITE;
                        end
                    end
                end
                ldcr_pkg::BUS_READ: begin
                    if (scl_fall) begin
                        if (bit_reg == 3'h7) begin
                            sda_oe_reg <= 1'b0;
                            bus_reg <= ldcr_pkg::BUS_RACK;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_oe_reg <= ~shift_reg[6];
                            bit_reg <= bit_reg + 3'h1;
                        end
                    end
                end
                ldcr_pkg::BUS_RACK: begin
                    if (scl_rise)
                        bus_reg <= sda_s ? ldcr_pkg::BUS_IDLE
                                         : ldcr_pkg::BUS_RLOAD;
                end
                ldcr_pkg::BUS_RLOAD: begin
                    if (scl_fall) begin
                        bit_reg <= 3'h0;
                        shift_reg <= rbyte;
                        sda_oe_reg <= ~rbyte[7];
                        ptr_reg <= ptr_reg + 8'h01;
                        bus_reg <= ldcr_pkg::BUS_READ;
                    end
                end
                default: bus_reg <= ldcr_pkg::BUS_IDLE;
            endcase
        end
    end

    // startup check
    ldcr_pkg::ldcr_start_t start_reg;
    logic conflict, high_clear;
    assign conflict = |(unpop_reg & en_low_reg);
    assign high_clear = (en_high_reg == 8'h00);
    logic running;
    assign running = (start_reg == ldcr_pkg::ST_RUN) && high_clear;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            start_reg <= ldcr_pkg::ST_WAIT;
        end else begin
            unique case (start_reg)
                ldcr_pkg::ST_WAIT:
                    if (startup_req_i)
                        start_reg <= ldcr_pkg::ST_CHECK;
                ldcr_pkg::ST_CHECK:
                    start_reg <= conflict ? ldcr_pkg::ST_HALT
                                          : ldcr_pkg::ST_RUN;
                ldcr_pkg::ST_RUN, ldcr_pkg::ST_HALT:
                    if (!startup_req_i)
                        start_reg <= ldcr_pkg::ST_WAIT;
            endcase
        end
    end

    // dimming period time base
    logic [4:0] step_reg;
    logic [12:0] pos_reg, per_act_reg;
    logic step_tick;
    assign step_tick = (step_reg == STEP_LAST);

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            step_reg <= 5'h00;
            pos_reg <= 13'h0000;
            per_act_reg <= {ldcr_pkg::RST_PER_HIGH, ldcr_pkg::RST_PER_LOW};
        end else begin
            step_reg <= step_tick ? 5'h00 : step_reg + 5'h01;
            if (!running) begin
                // idle: next period starts fresh from the live value
                pos_reg <= 13'h0000;
                per_act_reg <= {per_high_reg, per_low_reg};
            end else if (step_tick) begin
                if (pos_reg >= per_act_reg) begin
                    pos_reg <= 13'h0000;
                    per_act_reg <= {per_high_reg, per_low_reg};
                end else begin
                    pos_reg <= pos_reg + 13'h0001;
                end
            end
        end
    end

    // per-channel drive

    generate
        for (genvar k = 0; k < ldcr_pkg::NUM_CH; k++) begin : g_ch
            always_ff @(posedge mclk_i) begin
                if (!resetn_i)
                    led_on_o[k] <= 1'b0;
                else
                    led_on_o[k] <= running && en_low_reg[k]
                        && !unpop_reg[k]
                        && pos_reg < ontime_i[k]
                        && pos_reg < ONTIME_MAX;
            end
        end
    endgenerate

    // outputs
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            fault_n_o <= 1'b1;
            overvoltage_trip_code_o <= ldcr_pkg::RST_OVP;
            thermal_derate_enable_o <= ldcr_pkg::RST_DERATE;
            dither_o <= ldcr_pkg::DITHER_OFF;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            fault_n_o <= (start_reg != ldcr_pkg::ST_HALT);
            overvoltage_trip_code_o <= ovp_reg;
            thermal_derate_enable_o <= derate_reg;
            dither_o <= ext_sync_reg[1] ? ldcr_pkg::DITHER_OFF
                                        : dither_reg;
            sda_o <= 1'b0;
            sda_oe_o <= sda_oe_reg;
        end
    end

endmodule

`default_nettype wire

// File: tb/ldcr_host.sv
`timescale 1ns/10ps
`default_nettype none
module ldcr_host #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic bit_out(input logic b);
        sda_low_o <= !b;
        tick(5);
        scl_o <= 1'b1;
        tick(10);
        scl_o <= 1'b0;
        tick(5);
    endtask
    task automatic bit_in(output logic b);
        sda_low_o <= 1'b0;
        tick(5);
        scl_o <= 1'b1;
        tick(10);
        b = sda_i;
        scl_o <= 1'b0;
        tick(5);
    endtask
    task automatic start();
        tick(1);
        sda_low_o <= 1'b0;
        tick(5);
        scl_o <= 1'b1;
        tick(10);
        sda_low_o <= 1'b1;
        tick(10);
        scl_o <= 1'b0;
        tick(5);
    endtask
    task automatic stop();
        sda_low_o <= 1'b1;
        tick(5);
        scl_o <= 1'b1;
        tick(10);
        sda_low_o <= 1'b0;
        tick(10);
    endtask
    task automatic byte_out(input logic [7:0] v, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_in(a);
        ok = ok && !a;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        output logic ok);
        ok = 1'b1;
        start();
        byte_out({DEV_ADDR, 1'b0}, ok);
        byte_out(a, ok);
        byte_out(d, ok);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output logic ok);
        ok = 1'b1;
        start();
        byte_out({DEV_ADDR, 1'b0}, ok);
        byte_out(a, ok);
        start();
        byte_out({DEV_ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(1'b1);
        stop();
    endtask
endmodule
`default_nettype wire

// File: tb/ldcr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ldcr_monitor (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic [7:0] unpopulated_i,
    input wire logic freq_set_or_external_sync_pin_i,
    input wire logic startup_req_i,
    input wire logic [7:0][12:0] ontime_i,
    input wire logic [7:0] led_on_o,
    input wire logic fault_n_o,
    input wire logic [4:0] overvoltage_trip_code_o,
    input wire logic thermal_derate_enable_o,
    input wire logic [1:0] dither_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_req_rise;
        !startup_req_i ##1 startup_req_i;
    endsequence
    sequence s_flag_held;
        fault_n_o [*3];
    endsequence
    a_reset_outputs: assert property ($rose(resetn_i) |->
        overvoltage_trip_code_o == 5'h1c && !thermal_derate_enable_o &&
        dither_o == 2'h0 && fault_n_o && led_on_o == 8'h00)
        else $error("outputs wrong after reset");
    a_halt_not_early: assert property (s_req_rise |-> s_flag_held)
        else $error("fault flag fell too early");
    a_halt_dark: assert property (!fault_n_o |-> led_on_o == 8'h00)
        else $error("channel lit while halted");
    a_halt_needs_unpop: assert property ($fell(fault_n_o) |->
        $past(unpopulated_i, 4) != 8'h00)
        else $error("halt without unpopulated channel");
    a_halt_needs_req: assert property (!fault_n_o |->
        $past(startup_req_i, 2))
        else $error("halt without startup request");
    a_dark_without_run: assert property (|led_on_o |->
        $past(startup_req_i, 2))
        else $error("channel lit without startup");
    a_sync_no_dither: assert property (
        freq_set_or_external_sync_pin_i [*5] |-> dither_o == 2'h0)
        else $error("dither applied under external sync");
    a_zero_ontime_dark: assert property (
        (ontime_i[3] == 13'h0000) [*3] |-> !led_on_o[3])
        else $error("channel lit with zero on-time");
    a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
    a_ovp_scl_low: assert property (
        $changed(overvoltage_trip_code_o) |-> !scl_i)
        else $error("trip code moved mid bit");
endmodule
bind ldcr_top ldcr_monitor u_mon (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl_i),
    .sda_oe_o(sda_oe_o), .unpopulated_i(unpopulated_i),
    .freq_set_or_external_sync_pin_i(freq_set_or_external_sync_pin_i),
    .startup_req_i(startup_req_i), .ontime_i(ontime_i),
    .led_on_o(led_on_o), .fault_n_o(fault_n_o),
    .overvoltage_trip_code_o(overvoltage_trip_code_o),
    .thermal_derate_enable_o(thermal_derate_enable_o), .dither_o(dither_o)
);
`default_nettype wire

// File: tb/ldcr_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ldcr_top_tb_top;
    localparam int MAXS = 20;
    localparam int NPER = 29;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic sync = 1'b0;
    logic req = 1'b0;
    logic [7:0] unpop = 8'h00;
    logic [11:0] fev = 12'h000;
    logic [7:0][12:0] ot = {{4{13'h000a}}, 13'h0000, 13'h0019,
        13'h001e, 13'h000a};
    logic [7:0] rst_v [6] = '{8'h03, 8'hff, 8'h0f, 8'hff, 8'h1c, 8'h00};
    logic [7:0] full_v [6] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'h1f, 8'h07};
    logic scl, sda_low, sda_o, sda_oe, fault_n, derate;
    logic [7:0] led;
    logic [4:0] overvoltage_trip_code;
    logic [1:0] dither;
    wire logic sda_w = !(sda_low || (sda_oe && !sda_o));
    int n_mismatch = 0;
    int checks_done = 0;
    initial forever #25 mclk_i = ~mclk_i;
    ldcr_host u_host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_low_o(sda_low));
    ldcr_top #(.ONTIME_MAX_STEPS(MAXS)) u_dut (.mclk_i(mclk_i),
        .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .unpopulated_i(unpop),
        .freq_set_or_external_sync_pin_i(sync), .startup_req_i(req),
        .fault_event_i(fev), .ontime_i(ot), .led_on_o(led),
        .fault_n_o(fault_n), .overvoltage_trip_code_o(overvoltage_trip_code),
        .thermal_derate_enable_o(derate), .dither_o(dither));
    task automatic final_report();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        u_host.wr(a, d, ok);
        check("write ack", ok, 1'b1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        u_host.rd(a, d, ok);
        check("read ack", ok, 1'b1);
        check($sformatf("reg %h", a), d, e);
    endtask
    function automatic logic [31:0] exp_on(input int o);
        int s;
        s = o;
        if (s > MAXS) s = MAXS;
        if (s > NPER + 1) s = NPER + 1;
        return s * 2 * ldcr_pkg::STEP_CYCLES;
    endfunction
    task automatic measure(input logic [7:0] en);
        logic [31:0] c [8];
        c = '{default: 0};
        repeat (900) @(posedge mclk_i);
        repeat (1800) begin
            @(negedge mclk_i);
            for (int k = 0; k < 8; k++) c[k] += led[k];
        end
        for (int k = 0; k < 8; k++)
            check("led on", c[k], en[k] ? exp_on(ot[k]) : 0);
        @(posedge mclk_i);
    endtask
    initial begin
        repeat (100000) @(posedge mclk_i);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        for (int i = 0; i < 6; i++) rdc(i[7:0], rst_v[i]);
        rdc(8'h39, 8'h00);
        for (int i = 0; i < 6; i++) wr(i[7:0], 8'hff);
        for (int i = 0; i < 6; i++) rdc(i[7:0], full_v[i]);
        check("ovp", overvoltage_trip_code, 5'h1f);
        check("derate", derate, 1'b1);
        wr(8'h10, 8'h5a);
        rdc(8'h10, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h05, c[7:0]);
            check("dither", dither, c[1:0]);
            check("derate", derate, 1'b0);
        end
        sync <= 1'b1;
        repeat (8) @(posedge mclk_i);
        check("dither sync", dither, 2'h0);
        sync <= 1'b0;
        repeat (8) @(posedge mclk_i);
        check("dither", dither, 2'h3);
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h1d);
        req <= 1'b1;
        measure(8'h00);
        wr(8'h00, 8'h00);
        measure(8'hff);
        wr(8'h01, 8'hfe);
        req <= 1'b0;
        unpop <= 8'h01;
        repeat (4) @(posedge mclk_i);
        req <= 1'b1;
        measure(8'hfe);
        check("fault", fault_n, 1'b1);
        wr(8'h01, 8'hff);
        req <= 1'b0;
        repeat (4) @(posedge mclk_i);
        req <= 1'b1;
        repeat (8) @(negedge mclk_i);
        check("fault", fault_n, 1'b0);
        check("led", led, 8'h00);
        fev <= 12'h401;
        @(posedge mclk_i);
        fev <= 12'h000;
        rdc(8'h38, 8'h04);
        wr(8'h39, 8'h00);
        rdc(8'h39, 8'h01);
        wr(8'h01, 8'hfe);
        wr(8'h38, 8'h04);
        wr(8'h39, 8'h00);
        rdc(8'h38, 8'h00);
        rdc(8'h39, 8'h01);
        final_report();
    end
endmodule
`default_nettype wire
